// file: sysctl_pkg.sv
package sysctl_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] SYSCTL_IDX  = 16'hffc4;
   localparam logic [15:0] MODE_IDX    = 16'hffc5;
   localparam logic [15:0] SENSE_IDX   = 16'hffc6;
   localparam logic [15:0] IRQEN_IDX   = 16'hffc7;
   localparam int unsigned ADDR_W      = 18;

   // system_control fields
   localparam int unsigned SOFTWARE_STANDBY_SELECT_BIT    = 7;
   localparam int unsigned STS_LSB     = 4;
   localparam int unsigned STS_W       = 3;
   localparam int unsigned NMI_EDGE_SELECT_BIT   = 2;
   localparam int unsigned RAM_ENABLE_BIT_BIT    = 0;
   localparam logic [7:0]  SYSCTL_RST  = 8'h0b;
   localparam logic [7:0]  SYSCTL_WMSK = 8'hf5;
   localparam logic [7:0]  SYSCTL_ONES = 8'h0a;

   // mode_control: fixed upper pattern, pins in bits 1:0
   localparam logic [7:0]  MODE_FIXED  = 8'he4;
   localparam int unsigned MODE_W      = 2;

   // ext_int_sense: sense bits 2:0, edge bits 6:4
   localparam int unsigned NIRQ        = 3;
   localparam int unsigned SENSE_LSB   = 0;
   localparam int unsigned EDGE_LSB    = 4;
   localparam logic [7:0]  SENSE_RST   = 8'h00;
   localparam logic [7:0]  SENSE_ONES  = 8'h88;

   // ext_irq_enable
   localparam int unsigned IRQE_LSB    = 0;
   localparam logic [7:0]  IRQEN_RST   = 8'hf8;
   localparam logic [7:0]  IRQEN_ONES  = 8'hf8;

   // clock settling times in states; one state is one clock
   localparam int unsigned SETTLE_W    = 18;
   localparam int unsigned SETTLE_S0   = 8192;
   localparam int unsigned SETTLE_S1   = 16384;
   localparam int unsigned SETTLE_S2   = 32768;
   localparam int unsigned SETTLE_S3   = 65536;
   localparam int unsigned SETTLE_S4   = 131072;
   localparam int unsigned CLK_PER_ST  = 1;

   // pin synchroniser fill before mode pins are caught
   localparam logic [1:0]  MODE_CAP_AT = 2'h2;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_SLEEP,
      PWR_STANDBY,
      PWR_SETTLE
   } power_state_e;

endpackage : sysctl_pkg

// file: pin_sense.sv
`timescale 1ns/1ps
module pin_sense (
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   // pin and its configuration
   input  wire logic pin_in,
   input  wire logic edge_mode_in,
   input  wire logic rising_in,
   // results
   output logic      level_low_out,
   output logic      detect_out
);
   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic detect_r;
   wire  fall_w = prev_r & ~sync2_r;
   wire  rise_w = ~prev_r & sync2_r;
   wire  hit_w  = edge_mode_in & (rising_in ? rise_w : fall_w);

   // idle high so no false edge right after reset
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_r  <= 1'b1;
         sync2_r  <= 1'b1;
         prev_r   <= 1'b1;
         detect_r <= 1'b0;
      end else begin
         sync1_r  <= pin_in;
         sync2_r  <= sync1_r;
         prev_r   <= sync2_r;
         detect_r <= hit_w;
      end
   end

   assign level_low_out = ~sync2_r;
   assign detect_out    = detect_r;
endmodule : pin_sense

// file: settle_timer.sv
`timescale 1ns/1ps
module settle_timer
   import sysctl_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk_in,
   input  wire logic                rst_n_in,
   // control
   input  wire logic                start_in,
   input  wire logic [SETTLE_W-1:0] load_in,
   // status
   output logic                     busy_out,
   output logic                     done_out
);
   logic [SETTLE_W-1:0] cnt_r;
   logic                done_r;
   wire                 last_w = (cnt_r == SETTLE_W'(1));

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= last_w & ~start_in;
         if (start_in) begin
            cnt_r <= load_in;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - SETTLE_W'(1);
         end
      end
   end

   assign busy_out = (cnt_r != '0);
   assign done_out = done_r;
endmodule : settle_timer

// file: system_control_ext_irq.sv
`timescale 1ns/1ps
module system_control_ext_irq
   import sysctl_pkg::*;
#(
   parameter int unsigned SETTLE_0 = SETTLE_S0 * CLK_PER_ST,
   parameter int unsigned SETTLE_1 = SETTLE_S1 * CLK_PER_ST,
   parameter int unsigned SETTLE_2 = SETTLE_S2 * CLK_PER_ST,
   parameter int unsigned SETTLE_3 = SETTLE_S3 * CLK_PER_ST,
   parameter int unsigned SETTLE_4 = SETTLE_S4 * CLK_PER_ST
) (
   // clock and reset
   input  wire logic              ref_clk_in,
   input  wire logic              rst_n_in,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic      [31:0]       avs_readdata_out,
   output logic                   avs_waitrequest_out,
   // pins
   input  wire logic              nmi_pin_in,
   input  wire logic [NIRQ-1:0]   ext_int_pin_in,
   input  wire logic [MODE_W-1:0] mode_pin_in,
   // cpu side
   input  wire logic              sleep_in,
   input  wire logic              nmi_ack_in,
   input  wire logic [NIRQ-1:0]   irq_ack_in,
   output logic                   nmi_request_out,
   output logic      [NIRQ-1:0]   irq_request_out,
   // power and memory control
   output logic                   ram_enable_out,
   output logic                   sleep_mode_out,
   output logic                   standby_mode_out,
   output logic                   settling_out
);

   function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction : byte_addr

   function automatic logic [SETTLE_W-1:0] settle_len(
      input logic [STS_W-1:0] code);
      unique case (code)
         3'h0:    settle_len = SETTLE_W'(SETTLE_0);
         3'h1:    settle_len = SETTLE_W'(SETTLE_1);
         3'h2:    settle_len = SETTLE_W'(SETTLE_2);
         3'h3:    settle_len = SETTLE_W'(SETTLE_3);
         default: settle_len = SETTLE_W'(SETTLE_4);
      endcase
   endfunction : settle_len

   // ------------------------------------------------------------------
   // registers
   logic [7:0]         sysctl_r;
   logic [7:0]         sense_r;
   logic [NIRQ-1:0]    irq_en_r;
   logic [MODE_W-1:0]  mode_s1_r;
   logic [MODE_W-1:0]  mode_s2_r;
   logic [MODE_W-1:0]  mode_cap_r;
   logic [1:0]         cap_cnt_r;
   logic               ack_r;
   logic [31:0]        rdata_r;
   logic               nmi_pend_r;
   logic               nmi_pend_nxt;
   logic [NIRQ-1:0]    irq_pend_r;
   logic [NIRQ-1:0]    irq_pend_nxt;
   power_state_e       pwr_r;
   power_state_e       pwr_nxt;

   // ------------------------------------------------------------------
   // bus decode
   wire        req_w       = avs_read_in | avs_write_in;
   wire        wr_fire_w   = avs_write_in & ack_r & avs_byteenable_in[0];
   wire        hit_sys_w   = (avs_address_in == byte_addr(SYSCTL_IDX));
   wire        hit_mode_w  = (avs_address_in == byte_addr(MODE_IDX));
   wire        hit_sense_w = (avs_address_in == byte_addr(SENSE_IDX));
   wire        hit_irqen_w = (avs_address_in == byte_addr(IRQEN_IDX));
   wire [7:0]  wdata_w     = avs_writedata_in[7:0];

   // fixed one wait cycle keeps read data registered
   assign avs_waitrequest_out = req_w & ~ack_r;

   // ------------------------------------------------------------------
   // read mux; reserved bits read as 1, unmapped reads as 0
   wire [7:0] rd_sys_w   = sysctl_r | SYSCTL_ONES;
   wire [7:0] rd_mode_w  = MODE_FIXED | {6'h00, mode_cap_r};
   wire [7:0] rd_sense_w = sense_r | SENSE_ONES;
   wire [7:0] rd_irqen_w = IRQEN_ONES | {5'h00, irq_en_r};
   wire [7:0] rd_sel_w   = hit_sys_w   ? rd_sys_w   :
                           hit_mode_w  ? rd_mode_w  :
                           hit_sense_w ? rd_sense_w :
                           hit_irqen_w ? rd_irqen_w : 8'h00;

   // ------------------------------------------------------------------
   // field views
   wire                 software_standby_select_w   = sysctl_r[SOFTWARE_STANDBY_SELECT_BIT];
   wire [STS_W-1:0]     sts_w    = sysctl_r[STS_LSB +: STS_W];
   wire                 nmi_edge_select_w  = sysctl_r[NMI_EDGE_SELECT_BIT];
   wire [NIRQ-1:0]      sense_w  = sense_r[SENSE_LSB +: NIRQ];
   wire [NIRQ-1:0]      edge_w   = sense_r[EDGE_LSB +: NIRQ];

   // ------------------------------------------------------------------
   // pin front ends
   logic                nmi_det_w;
   logic [NIRQ-1:0]     irq_low_w;
   logic [NIRQ-1:0]     irq_det_w;

   pin_sense u_nmi_sense (
      .ref_clk_in    (ref_clk_in),
      .rst_n_in      (rst_n_in),
      .pin_in        (nmi_pin_in),
      .edge_mode_in  (1'b1),
      .rising_in     (nmi_edge_select_w),
      .level_low_out (),
      .detect_out    (nmi_det_w)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NIRQ; gi++) begin : g_irq
         pin_sense u_irq_sense (
            .ref_clk_in    (ref_clk_in),
            .rst_n_in      (rst_n_in),
            .pin_in        (ext_int_pin_in[gi]),
            .edge_mode_in  (sense_w[gi]),
            .rising_in     (edge_w[gi]),
            .level_low_out (irq_low_w[gi]),
            .detect_out    (irq_det_w[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // request logic; a new edge wins over an ack in the same cycle
   assign nmi_pend_nxt = nmi_det_w | (nmi_pend_r & ~nmi_ack_in);
   assign irq_pend_nxt = irq_det_w | (irq_pend_r & ~irq_ack_in);

   // level mode ignores the edge bit and follows the pin through the two-flop synchroniser
   wire [NIRQ-1:0] irq_raw_w = (sense_w & irq_pend_r)
                             | (~sense_w & irq_low_w);
   assign irq_request_out = irq_raw_w & irq_en_r;
   assign nmi_request_out = nmi_pend_r;

   // ------------------------------------------------------------------
   // power state machine
   wire wake_w = nmi_pend_r | (|irq_request_out);
   logic settle_start_w;
   logic settle_done_w;

   always_comb begin
      pwr_nxt        = pwr_r;
      settle_start_w = 1'b0;
      unique case (pwr_r)
         PWR_RUN: begin
            if (sleep_in) begin
               pwr_nxt = software_standby_select_w ? PWR_STANDBY : PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (wake_w) begin
               pwr_nxt = PWR_RUN;
            end
         end
         PWR_STANDBY: begin
            // oscillator restarts, so wait the chosen settling time
            if (wake_w) begin
               pwr_nxt        = PWR_SETTLE;
               settle_start_w = 1'b1;
            end
         end
         PWR_SETTLE: begin
            if (settle_done_w) begin
               pwr_nxt = PWR_RUN;
            end
         end
      endcase
   end

   settle_timer u_settle (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .start_in   (settle_start_w),
      .load_in    (settle_len(sts_w)),
      .busy_out   (),
      .done_out   (settle_done_w)
   );

   assign sleep_mode_out   = (pwr_r == PWR_SLEEP);
   assign standby_mode_out = (pwr_r == PWR_STANDBY);
   assign settling_out     = (pwr_r == PWR_SETTLE);
   assign ram_enable_out   = sysctl_r[RAM_ENABLE_BIT_BIT];
   assign avs_readdata_out = rdata_r;

   // ------------------------------------------------------------------
   // bus handshake and read data
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= req_w & ~ack_r;
         if (avs_read_in & ~ack_r) begin
            rdata_r <= {24'h00_0000, rd_sel_w};
         end
      end
   end

   // ------------------------------------------------------------------
   // writable registers; one strobe each keeps the blocks short
   wire wr_sys_w   = wr_fire_w & hit_sys_w;
   wire wr_sense_w = wr_fire_w & hit_sense_w;
   wire wr_irqen_w = wr_fire_w & hit_irqen_w;

   // read-as-one bits keep their reset value
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sysctl_r <= SYSCTL_RST;
      end else if (wr_sys_w) begin
         sysctl_r <= (wdata_w & SYSCTL_WMSK)
                   | (sysctl_r & ~SYSCTL_WMSK);
      end
   end

   // reserved bits stored as 0 and forced to 1 on read
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sense_r <= SENSE_RST;
      end else if (wr_sense_w) begin
         sense_r <= wdata_w & ~SENSE_ONES;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_en_r <= IRQEN_RST[NIRQ-1:0];
      end else if (wr_irqen_w) begin
         irq_en_r <= wdata_w[IRQE_LSB +: NIRQ];
      end
   end

   // ------------------------------------------------------------------
   // mode pins: synchronised, then caught once after reset release
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_s1_r <= '0;
         mode_s2_r <= '0;
      end else begin
         mode_s1_r <= mode_pin_in;
         mode_s2_r <= mode_s1_r;
      end
   end

   // the catch waits for a real sample in the second stage; later pin
   // moves are ignored so a glitch cannot change the reported mode
   wire cap_run_w = (cap_cnt_r != MODE_CAP_AT + 2'h1);
   wire cap_now_w = (cap_cnt_r == MODE_CAP_AT);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_cap_r <= '0;
         cap_cnt_r  <= 2'h0;
      end else begin
         if (cap_run_w) begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
         end
         if (cap_now_w) begin
            mode_cap_r <= mode_s2_r;
         end
      end
   end

   // ------------------------------------------------------------------
   // request registers
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nmi_pend_r <= 1'b0;
         irq_pend_r <= '0;
      end else begin
         nmi_pend_r <= nmi_pend_nxt;
         irq_pend_r <= irq_pend_nxt;
      end
   end

   // power state register
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwr_r <= PWR_RUN;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

endmodule : system_control_ext_irq

// file: sc_irq_asserts.sv
`timescale 1ns/1ps
module sc_irq_asserts
   import sysctl_pkg::*;
#(
   parameter int unsigned SETTLE_0 = SETTLE_S0,
   parameter int unsigned SETTLE_1 = SETTLE_S1,
   parameter int unsigned SETTLE_2 = SETTLE_S2,
   parameter int unsigned SETTLE_3 = SETTLE_S3,
   parameter int unsigned SETTLE_4 = SETTLE_S4
) (
   // clock and reset
   input  wire logic              ref_clk_in,
   input  wire logic              rst_n_in,
   // register bus
   input  wire logic [ADDR_W-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   input  wire logic [31:0]       avs_readdata_out,
   input  wire logic              avs_waitrequest_out,
   // cpu side and power
   input  wire logic              sleep_in,
   input  wire logic              nmi_ack_in,
   input  wire logic [NIRQ-1:0]   irq_ack_in,
   input  wire logic              nmi_request_out,
   input  wire logic [NIRQ-1:0]   irq_request_out,
   input  wire logic              ram_enable_out,
   input  wire logic              sleep_mode_out,
   input  wire logic              standby_mode_out,
   input  wire logic              settling_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [7:0]  sys_r;
   logic [2:0]  en_r;
   logic [2:0]  sense_r;
   int unsigned cnt_r;
   wire         wr_ok = avs_write_in && !avs_waitrequest_out
                        && avs_byteenable_in[0];
   wire [15:0]  idx   = avs_address_in[ADDR_W-1:2];
   wire         run   = !sleep_mode_out && !standby_mode_out && !settling_out;
   wire         wake  = nmi_request_out || (|irq_request_out);
   wire [2:0]   held  = irq_request_out & sense_r & ~irq_ack_in;
   wire [2:0]   sts   = sys_r[6:4];
   // codes above four reuse the longest wait
   wire [31:0]  lim   = sts == 3'h0 ? SETTLE_0 : sts == 3'h1 ? SETTLE_1 :
      sts == 3'h2 ? SETTLE_2 : sts == 3'h3 ? SETTLE_3 : SETTLE_4;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sys_r   <= SYSCTL_RST;
         en_r    <= 3'h0;
         sense_r <= 3'h0;
         cnt_r   <= 0;
      end else begin
         if (wr_ok && idx == SYSCTL_IDX) sys_r <= avs_writedata_in[7:0];
         if (wr_ok && idx == IRQEN_IDX) en_r <= avs_writedata_in[2:0];
         if (wr_ok && idx == SENSE_IDX) sense_r <= avs_writedata_in[2:0];
         cnt_r <= settling_out ? cnt_r + 1 : 0;
      end
   end
   sequence s_req_wait;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_go_sleep;
      sleep_in && run && !avs_write_in;
   endsequence
   a_wait_once: assert property (s_req_wait |=> !avs_waitrequest_out)
      else $error("bus answer late");
   a_ram_follow: assert property (ram_enable_out == sys_r[RAM_ENABLE_BIT_BIT])
      else $error("ram enable differs from register");
   a_sleep_entry: assert property (s_go_sleep |=>
      (sys_r[SOFTWARE_STANDBY_SELECT_BIT] ? standby_mode_out : sleep_mode_out))
      else $error("wrong low power mode");
   a_standby_wake: assert property (standby_mode_out && wake |=>
      settling_out)
      else $error("standby not left for settling");
   a_settle_span: assert property ($fell(settling_out) |->
      cnt_r >= lim && cnt_r <= lim + 2)
      else $error("settling time wrong");
   a_irq_gated: assert property ((irq_request_out & ~en_r) == 3'h0)
      else $error("disabled request passed");
   a_nmi_pending: assert property (nmi_request_out && !nmi_ack_in |=>
      nmi_request_out)
      else $error("nmi dropped before ack");
   a_edge_pending: assert property (|held && !avs_write_in |=>
      (irq_request_out & $past(held)) == $past(held))
      else $error("edge request dropped before ack");
   a_mode_fixed: assert property (avs_read_in && !avs_waitrequest_out
      && idx == MODE_IDX |-> avs_readdata_out[31:2] == 30'h39)
      else $error("mode register fixed bits wrong");
endmodule : sc_irq_asserts

bind system_control_ext_irq sc_irq_asserts #(.SETTLE_0(SETTLE_0),
   .SETTLE_1(SETTLE_1), .SETTLE_2(SETTLE_2), .SETTLE_3(SETTLE_3),
   .SETTLE_4(SETTLE_4)) u_chk (.ref_clk_in, .rst_n_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
   .avs_readdata_out, .avs_waitrequest_out, .sleep_in, .nmi_ack_in,
   .irq_ack_in, .nmi_request_out, .irq_request_out, .ram_enable_out,
   .sleep_mode_out, .standby_mode_out, .settling_out);

// file: pin_source.sv
`timescale 1ns/1ps
module pin_source (
   // clock
   input  wire logic ref_clk_in,
   // pins toward the block
   output logic       nmi_pin_out,
   output logic [2:0] ext_int_pin_out,
   output logic [1:0] mode_pin_out
);
   logic       n_r = 1'b1;
   logic [2:0] e_r = 3'h7;
   logic [1:0] m_r = 2'h0;

   // nmi and interrupt sources idle high; pins move at the edge after a call, so every
   // change lands just after a rising edge whatever the caller does
   always @(posedge ref_clk_in) begin
      nmi_pin_out     <= n_r;
      ext_int_pin_out <= e_r;
      mode_pin_out    <= m_r;
   end

   task automatic set_pins(input logic n, input logic [2:0] e,
                           input logic [1:0] m);
      n_r <= n;
      e_r <= e;
      m_r <= m;
   endtask : set_pins
endmodule : pin_source

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
   n_checks++; \
   if ((a) !== (b)) begin \
      n_fail++; \
      $display("mismatch %0t: got %h exp %h", $time, (a), (b)); \
   end \
end
module testbench
   import sysctl_pkg::*;
;
   logic              ref_clk_in = 1'b0;
   logic              rst_n_in = 1'b0;
   logic [ADDR_W-1:0] avs_address_in = '0;
   logic              avs_read_in = 1'b0;
   logic              avs_write_in = 1'b0;
   logic [31:0]       avs_writedata_in = '0;
   logic [3:0]        avs_byteenable_in = 4'hf;
   logic [31:0]       avs_readdata_out;
   logic              avs_waitrequest_out;
   logic              nmi_pin_in;
   logic [2:0]        ext_int_pin_in;
   logic [1:0]        mode_pin_in;
   logic              sleep_in = 1'b0;
   logic              nmi_ack_in = 1'b0;
   logic [2:0]        irq_ack_in = 3'h0;
   logic              nmi_request_out;
   logic [2:0]        irq_request_out;
   logic              ram_enable_out;
   logic              sleep_mode_out;
   logic              standby_mode_out;
   logic              settling_out;
   logic [7:0]        d;
   logic [1:0]        m;
   logic [2:0]        p;
   logic [31:0]       e;
   logic [31:0]       q[$];
   int                n_fail = 0;
   int                n_checks = 0;
   int                seed = 32'h9b4f7991;
   int                i;
   int                n;
   int                mo;
   int                lo;
   int unsigned       st[5] = '{8, 16, 32, 64, 128};

   system_control_ext_irq #(.SETTLE_0(8), .SETTLE_1(16), .SETTLE_2(32),
      .SETTLE_3(64), .SETTLE_4(128)) u_dut (.ref_clk_in, .rst_n_in,
      .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
      .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
      .nmi_pin_in, .ext_int_pin_in, .mode_pin_in, .sleep_in, .nmi_ack_in,
      .irq_ack_in, .nmi_request_out, .irq_request_out, .ram_enable_out,
      .sleep_mode_out, .standby_mode_out, .settling_out);
   pin_source u_pins (.ref_clk_in, .nmi_pin_out(nmi_pin_in),
      .ext_int_pin_out(ext_int_pin_in), .mode_pin_out(mode_pin_in));

   initial begin
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   // read data are taken at the edge where waitrequest is seen low
   always @(posedge ref_clk_in) begin
      if (avs_read_in && avs_waitrequest_out === 1'b0) begin
         e = q.size() > 0 ? q.pop_front() : 32'hffffffff;
         `CHK(avs_readdata_out, e)
      end
   end

   task automatic wt(input int c);
      repeat (c) @(posedge ref_clk_in);
   endtask : wt
   task automatic bus(input logic w, input logic [15:0] x,
                      input logic [7:0] v, input logic [3:0] be);
      @(posedge ref_clk_in);
      avs_address_in    <= {x, 2'h0};
      avs_writedata_in  <= {24'h0, v};
      avs_byteenable_in <= be;
      avs_read_in       <= !w;
      avs_write_in      <= w;
      // a slave that never answers is caught by the watchdog
      do begin
         @(posedge ref_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus
   task automatic wr(input logic [15:0] x, input logic [7:0] v);
      bus(1'b1, x, v, 4'hf);
   endtask : wr
   task automatic rd(input logic [15:0] x, input logic [7:0] v);
      q.push_back({24'h0, v});
      bus(1'b0, x, 8'h00, 4'hf);
   endtask : rd
   task automatic pulse(input logic s, input logic a, input logic [2:0] k);
      @(posedge ref_clk_in);
      sleep_in   <= s;
      nmi_ack_in <= a;
      irq_ack_in <= k;
      @(posedge ref_clk_in);
      sleep_in   <= 1'b0;
      nmi_ack_in <= 1'b0;
      irq_ack_in <= 3'h0;
   endtask : pulse
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   initial begin
      // the whole sequence needs a little over a thousand cycles
      repeat (40000) @(posedge ref_clk_in);
      n_fail++;
      conclude();
   end

   initial begin
      m = 2'($random(seed));
      u_pins.set_pins(1'b1, 3'h7, m);
      repeat (5) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      wt(5);
      `CHK(ram_enable_out, 1'b1)
      rd(SYSCTL_IDX, 8'h0b);
      rd(MODE_IDX, {6'h39, m});
      rd(SENSE_IDX, 8'h88);
      rd(IRQEN_IDX, 8'hf8);
      rd(16'hffc8, 8'h00);
      for (i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         wr(SYSCTL_IDX, d);
         rd(SYSCTL_IDX, d & 8'hf5 | 8'h0a);
         `CHK(ram_enable_out, d[0])
         wr(MODE_IDX, d);
         rd(MODE_IDX, {6'h39, m});
         wr(SENSE_IDX, d);
         rd(SENSE_IDX, d & 8'h77 | 8'h88);
         wr(IRQEN_IDX, d);
         rd(IRQEN_IDX, d & 8'h07 | 8'hf8);
      end
      bus(1'b1, IRQEN_IDX, 8'h07, 4'he);
      rd(IRQEN_IDX, d & 8'h07 | 8'hf8);
      for (i = 0; i < 12; i++) begin
         p  = 3'h1 << (i % 3);
         mo = i / 3;
         wr(IRQEN_IDX, 8'h07);
         wr(SENSE_IDX, {1'b0, {3{mo[0]}}, 1'b0, {3{mo[1]}}});
         pulse(1'b0, 1'b0, 3'h7);
         u_pins.set_pins(1'b1, ~p, m);
         wt(6);
         `CHK(irq_request_out, p & {3{mo != 3}})
         u_pins.set_pins(1'b1, 3'h7, m);
         wt(6);
         `CHK(irq_request_out, p & {3{mo[1]}})
         wr(IRQEN_IDX, 8'h00);
         wt(1);
         `CHK(irq_request_out, 3'h0)
         wr(IRQEN_IDX, 8'h07);
         wt(1);
         `CHK(irq_request_out, p & {3{mo[1]}})
         pulse(1'b0, 1'b0, p);
         wt(2);
         `CHK(irq_request_out, 3'h0)
      end
      for (i = 0; i < 2; i++) begin
         wr(SYSCTL_IDX, {5'h0, i[0], 2'h1});
         pulse(1'b0, 1'b1, 3'h0);
         u_pins.set_pins(1'b0, 3'h7, m);
         wt(6);
         `CHK(nmi_request_out, !i[0])
         u_pins.set_pins(1'b1, 3'h7, m);
         wt(6);
         `CHK(nmi_request_out, 1'b1)
         pulse(1'b0, 1'b1, 3'h0);
         wt(2);
         `CHK(nmi_request_out, 1'b0)
      end
      for (i = 0; i < 7; i++) begin
         wr(SYSCTL_IDX, i == 0 ? 8'h01 : {1'b1, 3'(i - 1), 4'h1});
         pulse(1'b1, 1'b0, 3'h0);
         wt(2);
         `CHK({sleep_mode_out, standby_mode_out}, i == 0 ? 2'h2 : 2'h1)
         u_pins.set_pins(1'b0, 3'h7, m);
         n = 0;
         while (i > 0 && settling_out !== 1'b1 && n < 20) begin
            @(negedge ref_clk_in);
            n++;
         end
         n = 0;
         while (i > 0 && settling_out === 1'b1 && n < 300) begin
            @(negedge ref_clk_in);
            n++;
         end
         wt(8);
         lo = i > 0 ? st[i > 5 ? 4 : i - 1] : 0;
         if (i > 0) `CHK(n >= lo && n <= lo + 2, 1'b1)
         `CHK({sleep_mode_out, standby_mode_out}, 2'h0)
         u_pins.set_pins(1'b1, 3'h7, m);
         pulse(1'b0, 1'b1, 3'h0);
         wt(4);
      end
      conclude();
   end
endmodule : testbench
